// *** rtl/tcp_unit.sv ***
// One 16-bit down-counting timer/counter/PWM instance
`timescale 1ns/100ps
module tcp_unit
   import tcp_pkg::*;
#(
   parameter int CNT_W = TCP_CNT_W,
   parameter int CLK_SRCS = TCP_CLK_SRCS,
   parameter int SEL_W = TCP_CLK_SEL_W,
   parameter int DB_W = TCP_DB_W
) (
   // Clock, reset, freeze
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Counting clock sources, each a one-cycle tick in ref_clk
   input wire logic [CLK_SRCS-1:0] clk_src,
   input wire logic [SEL_W-1:0] clk_sel,
   // Configuration
   input wire logic [1:0] run_mode,
   input wire logic [2:0] cmp_rel,
   input wire logic [CNT_W-1:0] period,
   input wire logic [CNT_W-1:0] compare,
   input wire logic [2:0] irq_en,
   input wire logic tc_as_compl,
   input wire logic [DB_W-1:0] deadband,
   // Firmware command
   input wire logic start,
   // Routing inputs
   input wire logic cnt_enable,
   input wire logic cnt_reset,
   input wire logic capture,
   input wire logic kill,
   // Outputs to routing
   output logic cmp_out,
   output logic tc_out,
   output logic irq,
   // Status for firmware
   output logic [CNT_W-1:0] count,
   output logic [CNT_W-1:0] captured,
   output logic running
);

   // Refuse parameter sets the logic cannot serve, at elaboration
   if (CNT_W < 2) begin : g_bad_cnt_w
      $error("tcp_unit: CNT_W too small");
   end
   if ((1 << SEL_W) < CLK_SRCS) begin : g_bad_sel_w
      $error("tcp_unit: SEL_W too narrow for CLK_SRCS");
   end
   if (CLK_SRCS < 1) begin : g_bad_srcs
      $error("tcp_unit: CLK_SRCS must be at least 1");
   end
   if (DB_W < 1) begin : g_bad_db_w
      $error("tcp_unit: DB_W must be at least 1");
   end

   // -------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   // Async assert, synchronous release through two flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic cmp_true(input logic [2:0] rel, input logic [CNT_W-1:0] a,
                                     input logic [CNT_W-1:0] b);
      case (tcp_cmp_t'(rel))
         cmp_less_than: cmp_true = a < b;
         cmp_less_or_equal: cmp_true = a <= b;
         cmp_equal: cmp_true = a == b;
         cmp_greater_or_equal: cmp_true = a >= b;
         cmp_greater_than: cmp_true = a > b;
         default: cmp_true = 1'b0;
      endcase
   endfunction : cmp_true

   // All state is local to this instance; nothing is shared between copies,
   // so the integrator can place four of them side by side without coupling
   typedef struct packed {
      tcp_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cap;
      logic cap_last;
      logic tc;
      logic cmp;
      logic irq;
   } tcp_unit_state_t;

   tcp_unit_state_t s_q, s_d;
   logic tick;
   logic cmp_now;
   logic pwm_hi;
   logic pwm_lo;

   // Selected counting clock; out-of-range select counts nothing
   assign tick = (32'(clk_sel) < CLK_SRCS) ? clk_src[clk_sel] : 1'b0;
   assign cmp_now = cmp_true(cmp_rel, s_q.cnt, compare);

   // -------------------------------------------------------------
   // Counter, modes, capture and interrupt
   // -------------------------------------------------------------
   always_comb begin
      logic step;
      step = 1'b0;
      s_d = s_q;
      s_d.tc = 1'b0;
      s_d.cap_last = capture;
      if (tick) begin
         s_d.cmp = cmp_now;
      end
      case (s_q.st)
         TCP_ST_IDLE: begin
            if (start) begin
               s_d.cnt = period;
               s_d.st = TCP_ST_RUN;
            end
         end
         TCP_ST_RUN: begin
            // Gated mode only advances while enable is high
            step = tick && ((tcp_mode_t'(run_mode) != TCP_MODE_GATED) || cnt_enable);
            if (step) begin
               if (s_q.cnt == TCP_CNT_ZERO) begin
                  s_d.cnt = period;
                  s_d.tc = 1'b1;
                  if (tcp_mode_t'(run_mode) == TCP_MODE_ONESHOT) begin
                     s_d.st = TCP_ST_HALT;
                  end
               end else begin
                  s_d.cnt = s_q.cnt - CNT_W'(1);
               end
            end
         end
         TCP_ST_HALT: begin
            if (start) begin
               s_d.cnt = period;
               s_d.st = TCP_ST_RUN;
            end
         end
         default: begin
            s_d.st = TCP_ST_IDLE;
         end
      endcase
      // Reset input reloads and wins over counting
      if (cnt_reset) begin
         s_d.cnt = period;
         s_d.tc = 1'b0;
      end
      // Rising edge of capture latches the live count
      if (capture && !s_q.cap_last) begin
         s_d.cap = s_q.cnt;
      end
      // Interrupt from any enabled event source; tc and capture give one-cycle pulses, cmp a level
      s_d.irq = (irq_en[TCP_IRQ_TC] && s_d.tc) || (irq_en[TCP_IRQ_CMP] && s_d.cmp) ||
                (irq_en[TCP_IRQ_CAP] && capture && !s_q.cap_last);
   end

   // State register, frozen while clk_en is low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: TCP_ST_IDLE, cnt: TCP_CNT_RST, cap: TCP_CNT_RST, default: '0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // Complementary pair with deadband and kill
   // -------------------------------------------------------------
   tcp_deadband #(
      .DB_W(DB_W)
   ) u_db (
      .clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .tick(tick),
      .db_len(deadband),
      .kill(kill),
      .cmp_in(s_q.cmp),
      .pwm_hi(pwm_hi),
      .pwm_lo(pwm_lo)
   );

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // With deadband unused, pwm_hi simply trails cmp by one counting clock tick
   assign cmp_out = pwm_hi;
   assign tc_out = tc_as_compl ? pwm_lo : s_q.tc;
   assign irq = s_q.irq;
   assign count = s_q.cnt;
   assign captured = s_q.cap;
   assign running = (s_q.st == TCP_ST_RUN);

endmodule : tcp_unit

// *** rtl/tcp_pkg.sv ***
// Package of constants and types for the timer/counter/PWM unit
package tcp_pkg;

   // -------------------------------------------------------------
   // Widths and counts
   // -------------------------------------------------------------
   localparam int TCP_CNT_W = 16;
   localparam int TCP_INSTANCES = 4;
   localparam int TCP_CLK_SRCS = 4;
   localparam int TCP_CLK_SEL_W = 2;
   localparam int TCP_DB_W = 8;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [TCP_CNT_W-1:0] TCP_CNT_RST = 16'h0000;
   localparam logic [TCP_CNT_W-1:0] TCP_CNT_ZERO = 16'h0000;
   localparam logic [TCP_DB_W-1:0] TCP_DB_ZERO = 8'h00;
   localparam logic [TCP_DB_W-1:0] TCP_DB_ONE = 8'h01;

   // -------------------------------------------------------------
   // Compare relations
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      cmp_less_than = 3'h0,
      cmp_less_or_equal = 3'h1,
      cmp_equal = 3'h2,
      cmp_greater_or_equal = 3'h3,
      cmp_greater_than = 3'h4
   } tcp_cmp_t;

   // -------------------------------------------------------------
   // Run modes
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      TCP_MODE_FREE = 2'h0,
      TCP_MODE_ONESHOT = 2'h1,
      TCP_MODE_GATED = 2'h2
   } tcp_mode_t;

   // -------------------------------------------------------------
   // Interrupt source select bits
   // -------------------------------------------------------------
   localparam int TCP_IRQ_TC = 0;
   localparam int TCP_IRQ_CMP = 1;
   localparam int TCP_IRQ_CAP = 2;

   // -------------------------------------------------------------
   // Run state
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      TCP_ST_IDLE = 2'h0,
      TCP_ST_RUN = 2'h1,
      TCP_ST_HALT = 2'h2
   } tcp_state_t;

endpackage : tcp_pkg

// *** rtl/tcp_deadband.sv ***
// Complementary output generator with deadband and kill
`timescale 1ns/100ps
module tcp_deadband
   import tcp_pkg::*;
#(
   parameter int DB_W = TCP_DB_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic tick,
   // Control
   input wire logic [DB_W-1:0] db_len,
   input wire logic kill,
   input wire logic cmp_in,
   // Outputs
   output logic pwm_hi,
   output logic pwm_lo
);

   // Refuse a gap counter the logic cannot serve, at elaboration
   if (DB_W < 1) begin : g_bad_db_w
      $error("tcp_deadband: DB_W must be at least 1");
   end

   typedef struct packed {
      logic last;
      logic [DB_W-1:0] cnt;
      logic hi;
      logic lo;
   } tcp_db_state_t;

   tcp_db_state_t s_q, s_d;

   // -------------------------------------------------------------
   // Deadband timing, counted in counting clock ticks
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (tick) begin
         s_d.last = cmp_in;
         if (cmp_in != s_q.last) begin
            // Both outputs drop on any edge and wait out the gap; a zero gap hands over at once
            s_d.cnt = db_len;
            s_d.hi = (db_len == '0) && cmp_in;
            s_d.lo = (db_len == '0) && !cmp_in;
         end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - DB_W'(1);
         end
         if ((cmp_in == s_q.last) && (s_q.cnt <= DB_W'(1))) begin
            s_d.hi = cmp_in;
            s_d.lo = ~cmp_in;
         end
      end
      if (kill) begin
         // Kill overrides at once, not on the next tick
         s_d.hi = 1'b0;
         s_d.lo = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign pwm_hi = s_q.hi;
   assign pwm_lo = s_q.lo;

endmodule : tcp_deadband

// *** verification/tcp_fabric_model.sv ***
// Routing-fabric model: tick sources at 1, 1/2, 1/4 and 1/8 of ref_clk
`timescale 1ns/100ps
module tcp_fabric_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Tick sources, one ref_clk cycle each
   output logic [3:0] clk_src
);
   logic [2:0] div_q;
   // Free divider; slow sources leave idle cycles between ticks
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   assign clk_src = {&div_q, &div_q[1:0], div_q[0], 1'b1};
endmodule : tcp_fabric_model

// *** verification/tcp_unit_checker.sv ***
// Concurrent checks for one timer/counter/PWM instance
`timescale 1ns/100ps
module tcp_unit_checker (
   // Clock, reset and inputs
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [3:0] clk_src,
   input wire logic [1:0] clk_sel,
   input wire logic [1:0] run_mode,
   input wire logic [15:0] period,
   input wire logic tc_as_compl,
   input wire logic [7:0] deadband,
   input wire logic cnt_enable,
   input wire logic cnt_reset,
   input wire logic kill,
   // Outputs
   input wire logic cmp_out,
   input wire logic tc_out,
   input wire logic [15:0] count,
   input wire logic running
);
   // Tick taken, then let through by the gate in gated mode
   wire logic tick = clk_en && clk_src[clk_sel];
   wire logic step = tick && (run_mode != 2'h2 || cnt_enable);
   wire logic live = running && !cnt_reset;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_steps_down: assert property (live && step && count != 16'h0 |=> count == $past(count) - 16'h1)
      else $error("count did not step down");
   a_tc_reload: assert property (live && step && count == 16'h0 && !tc_as_compl
      |=> count == $past(period) && tc_out) else $error("no reload at zero");
   a_single_halt: assert property (live && step && count == 16'h0 && run_mode == 2'h1 |=> !running)
      else $error("single shot kept running");
   a_gate_holds: assert property (live && run_mode == 2'h2 && !cnt_enable |=> $stable(count))
      else $error("gated count moved");
   a_idle_holds: assert property (live && !tick |=> $stable(count)) else $error("moved without tick");
   a_reset_load: assert property (running && clk_en && cnt_reset |=> count == $past(period))
      else $error("reset input did not reload");
   a_kill_blank: assert property (clk_en && kill |=> !cmp_out && !(tc_as_compl && tc_out))
      else $error("output active under kill");
   a_pair_apart: assert property (tc_as_compl && $past(tc_as_compl, 3) |-> !(cmp_out && tc_out))
      else $error("both outputs active");
   a_gap_kept: assert property (tc_as_compl && $past(tc_as_compl) && $past(deadband) != 8'h0
      && ($rose(cmp_out) || $rose(tc_out)) |-> !$past(cmp_out) && !$past(tc_out))
      else $error("pair handed over with no gap");
   // Main scenarios reached
   c_tc: cover property (tc_out && !tc_as_compl);
   c_halt: cover property ($fell(running));
   c_kill: cover property (kill && tc_as_compl);
endmodule : tcp_unit_checker
bind tcp_unit tcp_unit_checker chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .clk_src(clk_src), .clk_sel(clk_sel),
   .run_mode(run_mode), .period(period), .tc_as_compl(tc_as_compl), .deadband(deadband),
   .cnt_enable(cnt_enable), .cnt_reset(cnt_reset), .kill(kill), .cmp_out(cmp_out), .tc_out(tc_out),
   .count(count), .running(running)
);

// *** verification/tb_tcp_unit.sv ***
// Self-checking bench for one timer/counter/PWM instance
`timescale 1ns/100ps
module tb_tcp_unit;
   logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, tc_as_compl = 1'b0, start = 1'b0, cnt_enable = 1'b0;
   logic cnt_reset = 1'b0, capture = 1'b0, kill = 1'b0, hit, cmp_out, tc_out, irq, running;
   logic [1:0] clk_sel = 2'h0, run_mode = 2'h0;
   logic [2:0] cmp_rel = 3'h0, irq_en = 3'h0;
   logic [15:0] period = 16'h20, compare = 16'h10, count, captured;
   logic [7:0] deadband = 8'h0;
   logic [3:0] clk_src;
   logic [31:0] seed = 32'd71085;
   int fails = 0, samples_checked = 0, m_cnt = 0, m_run = 0, m_tc = 0, chk = 0, cq = 0, rs = 0;
   int hist[$];
   // Unit under test and the fabric that feeds its ticks
   tcp_unit dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .clk_src(clk_src), .clk_sel(clk_sel),
      .run_mode(run_mode), .cmp_rel(cmp_rel), .period(period), .compare(compare), .irq_en(irq_en),
      .tc_as_compl(tc_as_compl), .deadband(deadband), .start(start), .cnt_enable(cnt_enable),
      .cnt_reset(cnt_reset), .capture(capture), .kill(kill), .cmp_out(cmp_out), .tc_out(tc_out),
      .irq(irq), .count(count), .captured(captured), .running(running)
   );
   tcp_fabric_model fab (
      .ref_clk(ref_clk), .arst_n(arst_n), .clk_src(clk_src)
   );
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // Relation the comparator should apply to a past count
   function automatic logic rel(input int c);
      case (cmp_rel)
         3'h0: return c < compare;
         3'h1: return c <= compare;
         3'h2: return c == compare;
         3'h3: return c >= compare;
         default: return c > compare;
      endcase
   endfunction : rel
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   // Watch irq over a window, since it may be a short pulse
   task automatic see_irq(input int n);
      hit = 1'b0;
      repeat (n) begin
         @(negedge ref_clk);
         hit = hit | irq;
      end
      check(hit, 1'b1);
      cyc(1);
   endtask : see_irq
   // Reference counter, fed the same inputs on the same edge
   always @(posedge ref_clk) begin
      m_tc = 0;
      if (rs != 3) begin
         m_run = 0;
         m_cnt = 0;
      end else if (!m_run && start) begin
         m_run = 1;
         m_cnt = period;
      end else if (m_run && cnt_reset) begin
         m_cnt = period;
      end else if (m_run && clk_src[clk_sel] && (run_mode != 2'h2 || cnt_enable)) begin
         m_tc = m_cnt == 0;
         m_cnt = m_tc ? period : m_cnt - 1;
         m_run = !(m_tc && run_mode == 2'h1);
      end
      rs = {rs[0], arst_n};
   end
   // Compare with the reference once outputs have settled
   always @(negedge ref_clk) begin
      if (rs == 3) begin
         check(count, m_cnt[15:0]);
         check(running, m_run[0]);
         if (!tc_as_compl && !cq) check(tc_out, m_tc[0]);
         hist.push_back(count);
         if (chk > 3) check(cmp_out, rel(hist[$-2]));
         chk = chk + (chk > 0);
         cq = tc_as_compl;
      end
   end
   initial begin
      cyc(6);
      arst_n <= 1'b1;
      cyc(3);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      // Free running on each tick source, random period
      for (int s = 0; s < 4; s++) begin
         seed = lfsr(seed);
         clk_sel <= s[1:0];
         period <= {12'h0, seed[3:0]} + 16'h2;
         cyc(64 << s);
      end
      // Every compare relation, ticking each cycle
      clk_sel <= 2'h0;
      period <= 16'h20;
      for (int r = 0; r < 5; r++) begin
         cmp_rel <= r[2:0];
         chk = 1;
         cyc(40);
      end
      chk = 0;
      kill <= 1'b1;
      cyc(6);
      kill <= 1'b0;
      // Gated counting with random enable and a reload mid-way
      run_mode <= 2'h2;
      for (int i = 0; i < 100; i++) begin
         seed = lfsr(seed);
         cnt_enable <= seed[0];
         cnt_reset <= i == 50;
         cyc(1);
      end
      // Capture a frozen count, then interrupts from each source
      cnt_enable <= 1'b0;
      irq_en <= 3'h4;
      cyc(2);
      capture <= 1'b1;
      see_irq(8);
      @(negedge ref_clk);
      check(captured, m_cnt[15:0]);
      cyc(1);
      run_mode <= 2'h0;
      irq_en <= 3'h1;
      see_irq(40);
      irq_en <= 3'h2;
      see_irq(40);
      irq_en <= 3'h0;
      // Complementary pair with a three-tick deadband, killed briefly
      // Reload first, so no terminal count meets the switch of tc_out
      cnt_reset <= 1'b1;
      cyc(1);
      cnt_reset <= 1'b0;
      tc_as_compl <= 1'b1;
      deadband <= 8'h3;
      cyc(100);
      kill <= 1'b1;
      cyc(4);
      kill <= 1'b0;
      cyc(40);
      tc_as_compl <= 1'b0;
      // Single shot halts and waits for a fresh start
      run_mode <= 2'h1;
      cyc(80);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(80);
      close_out();
   end
endmodule : tb_tcp_unit
